/* design/apm_defs.svh */
// constants for the drive power-mode sequencer
`ifndef APM_DEFS_SVH
`define APM_DEFS_SVH

// main clock rate and the inactivity interval before sleep
`define APM_CLK_FREQ_MHZ     125
`define APM_SLEEP_TIME_US    16000
`define APM_SLEEP_CYCLES     (`APM_SLEEP_TIME_US * `APM_CLK_FREQ_MHZ)

// width of the inactivity counter and the firmware timeout value
`define APM_TMO_W            24

// state encodings
`define APM_ST_ACTIVE        2'h0
`define APM_ST_IDLE          2'h1
`define APM_ST_SLEEP         2'h2
`define APM_ST_WAKE          2'h3

// level of a synchronised pin that means an installed jumper
`define APM_JUMPER_ON        1'h1
// cable select line level that selects the master role
`define APM_CSEL_MASTER      1'h0

`endif

/* design/apm_pkg.sv */
// types shared by the drive power-mode sequencer
package apm_pkg;

   typedef enum logic [1:0] {
      APM_ACTIVE = 2'h0,
      APM_IDLE   = 2'h1,
      APM_SLEEP  = 2'h2,
      APM_WAKE   = 2'h3
   } apm_mode_t;

   // what the rest of the drive sees of the sequencer
   typedef struct packed {
      apm_mode_t mode;
      logic      main_clk_en;
      logic      is_slave;
   } apm_status_t;

   // one-cycle starts handed to the command engine
   typedef struct packed {
      logic cmd_start;
      logic srst_start;
   } apm_start_t;

endpackage

/* design/apm_power_seq.sv */
// power-mode sequencer and drive role selection for the ata drive
`timescale 1ns/10ps
`include "apm_defs.svh"

module apm_power_seq #(
   parameter int unsigned            TMO_W        = `APM_TMO_W,
   parameter logic [`APM_TMO_W-1:0]  SLEEP_CYCLES = `APM_TMO_W'(`APM_SLEEP_CYCLES),
   parameter bit                     HORIZONTAL   = 1'b0
) (
   // clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 reset_n_i,
   // host activity from the ata register file
   input  wire logic                 cmd_write_i,
   input  wire logic                 soft_reset_i,
   input  wire logic                 cmd_done_i,
   // firmware timeout setting
   input  wire logic                 timeout_load_i,
   input  wire logic [TMO_W-1:0]     timeout_value_i,
   // configuration pins
   input  wire logic                 drive_select_jumper_i,
   input  wire logic                 cable_select_jumper_i,
   input  wire logic                 cable_select_i,
   // results
   output apm_pkg::apm_status_t      status_o,
   output apm_pkg::apm_start_t       start_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] jmp_sync_r;
   logic [1:0] csj_sync_r;
   logic [1:0] csl_sync_r;
   logic [1:0] jmp_sync_nxt;
   logic [1:0] csj_sync_nxt;
   logic [1:0] csl_sync_nxt;

   always_comb begin
      jmp_sync_nxt = {jmp_sync_r[0], drive_select_jumper_i};
      csj_sync_nxt = {csj_sync_r[0], cable_select_jumper_i};
      csl_sync_nxt = {csl_sync_r[0], cable_select_i};
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         jmp_sync_r <= 2'h0;
         csj_sync_r <= 2'h0;
         csl_sync_r <= 2'h0;
      end else begin
         jmp_sync_r <= jmp_sync_nxt;
         csj_sync_r <= csj_sync_nxt;
         csl_sync_r <= csl_sync_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // sequencer state
   apm_pkg::apm_mode_t    mode_r;
   apm_pkg::apm_mode_t    mode_nxt;
   logic [TMO_W-1:0]      idle_cnt_r;
   logic [TMO_W-1:0]      idle_cnt_nxt;
   logic [TMO_W-1:0]      tmo_r;
   logic [TMO_W-1:0]      tmo_nxt;
   logic                  pend_cmd_r;
   logic                  pend_cmd_nxt;
   logic                  pend_srst_r;
   logic                  pend_srst_nxt;
   apm_pkg::apm_status_t  status_r;
   apm_pkg::apm_status_t  status_nxt;
   apm_pkg::apm_start_t   start_r;
   apm_pkg::apm_start_t   start_nxt;
   logic                  activity;
   logic                  role_slave;

   assign activity = cmd_write_i | soft_reset_i;

   always_comb begin
      mode_nxt      = mode_r;
      idle_cnt_nxt  = idle_cnt_r;
      tmo_nxt       = tmo_r;
      pend_cmd_nxt  = pend_cmd_r;
      pend_srst_nxt = pend_srst_r;
      start_nxt     = '0;
      // a zero interval is stored as one, so the quiet interval is never shorter than one cycle
      if (timeout_load_i) begin
         tmo_nxt = (timeout_value_i == '0) ? TMO_W'(1) : timeout_value_i;
      end
      unique case (mode_r)
         apm_pkg::APM_ACTIVE: begin
            idle_cnt_nxt = '0;
            // new activity in the cycle of completion wins and keeps us active
            if (activity) begin
               start_nxt.cmd_start  = cmd_write_i;
               start_nxt.srst_start = soft_reset_i;
            end else if (cmd_done_i) begin
               mode_nxt = apm_pkg::APM_IDLE;
            end
         end
         apm_pkg::APM_IDLE: begin
            if (activity) begin
               mode_nxt             = apm_pkg::APM_ACTIVE;
               idle_cnt_nxt         = '0;
               start_nxt.cmd_start  = cmd_write_i;
               start_nxt.srst_start = soft_reset_i;
            end else if (idle_cnt_r + TMO_W'(1) >= tmo_r) begin
               mode_nxt     = apm_pkg::APM_SLEEP;
               idle_cnt_nxt = '0;
            end else begin
               idle_cnt_nxt = idle_cnt_r + TMO_W'(1);
            end
         end
         apm_pkg::APM_SLEEP: begin
            idle_cnt_nxt = '0;
            // the request is parked until the clock is running again
            if (activity) begin
               mode_nxt      = apm_pkg::APM_WAKE;
               pend_cmd_nxt  = cmd_write_i;
               pend_srst_nxt = soft_reset_i;
            end
         end
         apm_pkg::APM_WAKE: begin
            mode_nxt             = apm_pkg::APM_ACTIVE;
            start_nxt.cmd_start  = pend_cmd_r | cmd_write_i;
            start_nxt.srst_start = pend_srst_r | soft_reset_i;
            pend_cmd_nxt         = 1'b0;
            pend_srst_nxt        = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // role selection and registered outputs
   always_comb begin
      if (HORIZONTAL && csj_sync_r[1] == `APM_JUMPER_ON) begin
         role_slave = (csl_sync_r[1] != `APM_CSEL_MASTER);
      end else begin
         role_slave = (jmp_sync_r[1] == `APM_JUMPER_ON);
      end
      status_nxt.mode        = mode_nxt;
      // the gate drops with the state so the sleep cycle already runs clockless
      status_nxt.main_clk_en = (mode_nxt != apm_pkg::APM_SLEEP);
      status_nxt.is_slave    = role_slave;
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_r      <= apm_pkg::APM_IDLE;
         idle_cnt_r  <= '0;
         tmo_r       <= TMO_W'(SLEEP_CYCLES);
         pend_cmd_r  <= 1'b0;
         pend_srst_r <= 1'b0;
         status_r    <= '{mode: apm_pkg::APM_IDLE, main_clk_en: 1'b1, is_slave: 1'b0};
         start_r     <= '0;
      end else begin
         mode_r      <= mode_nxt;
         idle_cnt_r  <= idle_cnt_nxt;
         tmo_r       <= tmo_nxt;
         pend_cmd_r  <= pend_cmd_nxt;
         pend_srst_r <= pend_srst_nxt;
         status_r    <= status_nxt;
         start_r     <= start_nxt;
      end
   end

   assign status_o = status_r;
   assign start_o  = start_r;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);

   a_idle_to_active: assert property (
      (mode_r == apm_pkg::APM_IDLE && activity) |=> status_o.mode == apm_pkg::APM_ACTIVE)
      else $error("activity in idle did not enter active");

   a_active_runs_cmd: assert property (
      (mode_r == apm_pkg::APM_ACTIVE && cmd_write_i) |=> start_o.cmd_start)
      else $error("command in active was not started");

   a_done_to_idle: assert property (
      (mode_r == apm_pkg::APM_ACTIVE && cmd_done_i && !activity)
      |=> status_o.mode == apm_pkg::APM_IDLE)
      else $error("completion did not return to idle");

   a_sleep_on_quiet: assert property (
      (mode_r == apm_pkg::APM_IDLE && !activity && idle_cnt_r + TMO_W'(1) == tmo_r)
      |=> status_o.mode == apm_pkg::APM_SLEEP)
      else $error("quiet interval did not lead to sleep");

   a_no_early_sleep: assert property (
      (mode_r == apm_pkg::APM_IDLE && idle_cnt_r + TMO_W'(1) < tmo_r)
      |=> mode_r != apm_pkg::APM_SLEEP)
      else $error("sleep entered before the interval ran out");

   a_timeout_load: assert property (
      (timeout_load_i && timeout_value_i != '0) |=> tmo_r == $past(timeout_value_i))
      else $error("firmware timeout not taken");

   a_clock_gate: assert property (
      status_o.main_clk_en == (status_o.mode != apm_pkg::APM_SLEEP))
      else $error("clock gate does not follow sleep");

   a_wake_path: assert property (
      (mode_r == apm_pkg::APM_SLEEP && cmd_write_i)
      |=> status_o.main_clk_en ##1 (start_o.cmd_start && status_o.mode == apm_pkg::APM_ACTIVE))
      else $error("command in sleep not kept across wake");

   // the role is registered, so it lags the synchronised pin by one cycle
   a_role_pins: assert property (
      (!(HORIZONTAL && csj_sync_r[1]) && $stable(jmp_sync_r[1]))
      |=> status_o.is_slave == ($past(jmp_sync_r[1]) == `APM_JUMPER_ON))
      else $error("role does not follow the jumper");

endmodule

/* dv/apm_host_model.sv */
// host side model: answers the latest start with a completion after a set delay
`timescale 1ns/10ps
module apm_host_model (
   // clock and reset
   input  wire logic          clock_i,
   input  wire logic          reset_n_i,
   // delay in cycles from start to completion, 1 or more
   input  wire logic [3:0]    dly_i,
   // command engine handshake
   input  apm_pkg::apm_start_t start_i,
   output logic               cmd_done_o
);
   logic [3:0] cnt_r;

   // a completion only ever follows a start, so the sequencer is never handed a stray one
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_r <= 4'h0;
         cmd_done_o <= 1'b0;
      end else begin
         cmd_done_o <= (cnt_r == 4'h1);
         if (start_i.cmd_start | start_i.srst_start) begin
            cnt_r <= dly_i;
         end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule

/* dv/ata_drive_power_mode_control_tb.sv */
// self-checking bench for the drive power-mode sequencer
`timescale 1ns/10ps
module ata_drive_power_mode_control_tb;
   localparam int T = 20;
   logic                 clock_i = 1'b0;
   logic                 reset_n_i = 1'b0;
   logic                 cmd_write = 1'b0;
   logic                 soft_reset = 1'b0;
   logic                 tload = 1'b0;
   logic                 jmp = 1'b0;
   logic                 csj = 1'b0;
   logic                 csl = 1'b0;
   logic                 done;
   logic [3:0]           dly = 4'h3;
   logic [23:0]          tval = 24'h000005;
   int                   num_errors = 0;
   int                   samples_checked = 0;
   apm_pkg::apm_status_t st;
   apm_pkg::apm_status_t st_h;
   apm_pkg::apm_start_t  sta;

   always #4 clock_i = ~clock_i;

   // short quiet interval keeps the run brief
   apm_power_seq #(.SLEEP_CYCLES(24'h000014)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .cmd_write_i(cmd_write), .soft_reset_i(soft_reset), .cmd_done_i(done),
      .timeout_load_i(tload), .timeout_value_i(tval), .drive_select_jumper_i(jmp),
      .cable_select_jumper_i(csj), .cable_select_i(csl), .status_o(st), .start_o(sta));
   apm_power_seq #(.HORIZONTAL(1'b1)) dut_h (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .cmd_write_i(cmd_write), .soft_reset_i(soft_reset), .cmd_done_i(done),
      .timeout_load_i(tload), .timeout_value_i(tval), .drive_select_jumper_i(jmp),
      .cable_select_jumper_i(csj), .cable_select_i(csl), .status_o(st_h), .start_o());
   apm_host_model host (.clock_i(clock_i), .reset_n_i(reset_n_i), .dly_i(dly),
      .start_i(sta), .cmd_done_o(done));

   task automatic results();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // inputs always change 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic pulse(input logic c, input logic s, input logic l);
      cmd_write = c;
      soft_reset = s;
      tload = l;
      step(1);
      cmd_write = 1'b0;
      soft_reset = 1'b0;
      tload = 1'b0;
   endtask

   task automatic wait_mode(input apm_pkg::apm_mode_t m);
      int i;
      for (i = 0; i < 50 && st.mode !== m; i++) step(1);
      if (st.mode !== m) begin
         num_errors++;
         results();
      end
   endtask

   // entered idle on the last edge: asleep exactly n idle edges later
   task automatic idle_to_sleep(input int n);
      step(n - 1);
      check(4'(st.mode), 4'(apm_pkg::APM_IDLE));
      step(1);
      check(4'(st.mode), 4'(apm_pkg::APM_SLEEP));
      check(4'(st.main_clk_en), 4'h0);
   endtask

   task automatic t_cmd(input int n);
      pulse(1'b1, 1'b0, 1'b0);
      check(4'(st.mode), 4'(apm_pkg::APM_ACTIVE));
      check(4'(sta), 4'h2);
      step(1);
      check(4'(sta), 4'h0);
      wait_mode(apm_pkg::APM_IDLE);
      idle_to_sleep(n);
   endtask

   // wake from sleep, then a soft reset halfway through the quiet interval
   task automatic t_wake(input logic s);
      pulse(!s, s, 1'b0);
      check(4'(st.mode), 4'(apm_pkg::APM_WAKE));
      check(4'(st.main_clk_en), 4'h1);
      step(1);
      check(4'(st.mode), 4'(apm_pkg::APM_ACTIVE));
      check(4'(sta), s ? 4'h1 : 4'h2);
      wait_mode(apm_pkg::APM_IDLE);
      step(T / 2);
      pulse(1'b0, 1'b1, 1'b0);
      check(4'(st.mode), 4'(apm_pkg::APM_ACTIVE));
      wait_mode(apm_pkg::APM_IDLE);
      idle_to_sleep(T);
   endtask

   // hardware reset out of sleep, then a firmware interval of n cycles (zero is held at one)
   task automatic t_hw_reset(input logic [23:0] v, input int n);
      reset_n_i = 1'b0;
      #1;
      check(4'(st.mode), 4'(apm_pkg::APM_IDLE));
      check(4'(st.main_clk_en), 4'h1);
      step(1);
      reset_n_i = 1'b1;
      step(1);
      tval = v;
      pulse(1'b0, 1'b0, 1'b1);
      t_cmd(n);
   endtask

   // jumper alone, then the cable select position, which only the horizontal variant honours
   task automatic t_role();
      jmp = 1'b1;
      step(3);
      check(4'(st.is_slave), 4'h1);
      check(4'(st_h.is_slave), 4'h1);
      csj = 1'b1;
      step(3);
      check(4'(st.is_slave), 4'h1);
      check(4'(st_h.is_slave), 4'h0);
      csl = 1'b1;
      step(3);
      check(4'(st_h.is_slave), 4'h1);
      jmp = 1'b0;
      step(3);
      check(4'(st.is_slave), 4'h0);
      check(4'(st_h.is_slave), 4'h1);
   endtask

   initial begin
      step(8);
      check(4'(st.mode), 4'(apm_pkg::APM_IDLE));
      reset_n_i = 1'b1;
      step(3);
      check(4'(st.is_slave), 4'h0);
      t_cmd(T);
      t_wake(1'b0);
      dly = 4'h9;
      t_wake(1'b1);
      t_hw_reset(24'h000005, 5);
      t_hw_reset(24'h000000, 1);
      t_role();
      results();
   end
endmodule
